/* rtl/ccsw_top.sv */
// ccsw_top: cpu clock source selection with oscillator watchdog
// assumes crystal_input and straps are asynchronous pins, the watchdog
// disable level comes from configuration logic on the same clock
//
// Notes on behaviour
// - the clock mode is caught from the strap pins at reset and kept afterwards.
// - strap codes 111..000 select factors 4,3,2,5,1,1.5,0.5,2.5.
// - code 001 makes the cpu clock the input clock divided by two.
// - in prescaler mode each cpu phase lasts exactly one input period.
// - code 011 bypasses the multiplier and passes the input clock through.
// - in direct mode the cpu phases follow the input duty cycle.
// - the watchdog is on after reset and is switched off by the disable bit.
// - with the watchdog on, the free-running pll clock advances the watchdog counter.
// - every input clock transition clears the watchdog counter.
// - with no input transitions the counter overflows after 16 free cycles.
// - overflow moves the cpu clock to the free clock and raises the failure interrupt.
// - after the move the cpu clock stays on the free clock until hardware reset.
// - with the watchdog off before any failure the cpu clock comes from the input and the pll is off.
// - every cpu clock edge, rising or falling, is marked for downstream logic.
// - other codes multiply the input by the factor and resynchronise periodically.
`timescale 1ns/10ps
`default_nettype none
module ccsw_top (
   // clock and reset
   input  wire logic              CLK_IN,
   input  wire logic              RSTN_IN,
   // pins
   input  wire logic              CRYSTAL_INPUT_IN,
   input  wire logic [2:0]        CLOCK_MODE_STRAP_PINS_IN,
   // configuration
   input  wire logic              OSC_WATCHDOG_DISABLE_IN,
   // clock out
   output logic                   CPU_CLK_OUT,
   output logic                   CPU_EDGE_OUT,
   // status
   output logic                   OSC_FAIL_INTERRUPT_OUT,
   output logic                   CLK_FAILED_OUT,
   output logic                   PLL_ON_OUT,
   output ccsw_pkg::ccsw_cfg_t    CLOCK_MODE_OUT
);
   import ccsw_pkg::*;

   // ------------------------------------------------------------
   // declarations
   // ------------------------------------------------------------
   logic                xtal_s;
   logic                xtal_q;
   logic [2:0]          clock_mode_straps;
   logic                xtal_edge;
   logic                xtal_rise;
   logic                cfg_done;
   ccsw_cfg_t           cfg;
   logic                wdog_en;
   logic                free_run;
   logic [1:0]          free_cnt;
   logic                free_clk;
   logic                next_free_clk;
   logic                free_rise;
   logic                free_fall_now;
   logic [4:0]          wdog_cnt;
   logic                ovf;
   ccsw_src_t           src;
   logic [PERIOD_W-1:0] per_cnt;
   logic [PERIOD_W-1:0] period;
   logic [3:0]          trans_cnt;
   logic [PERIOD_W:0]   acc;
   logic [PERIOD_W:0]   acc_sum;
   logic                pll_tog;
   logic                next_cpu;
   logic                use_direct;

   // ------------------------------------------------------------
   // pin synchronisers
   // ------------------------------------------------------------
   ccsw_sync #(.W(1)) u_sync_xtal (
      .clk_in (CLK_IN),
      .d_in   (CRYSTAL_INPUT_IN),
      .q_out  (xtal_s)
   );

   ccsw_sync #(.W(3)) u_sync_strap (
      .clk_in (CLK_IN),
      .d_in   (CLOCK_MODE_STRAP_PINS_IN),
      .q_out  (clock_mode_straps)
   );

   // input edge detection; no reset, so a high pin at release is no false edge
   always_ff @(posedge CLK_IN) begin
      xtal_q <= xtal_s;
   end

   assign xtal_edge = xtal_s ^ xtal_q;
   assign xtal_rise = xtal_s & ~xtal_q;

   // ------------------------------------------------------------
   // strap capture
   // ------------------------------------------------------------
   // mode taken at the first edge after release, then frozen
   always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
      if (!RSTN_IN) begin
         cfg_done <= 1'b0;
         cfg      <= CFG_RESET;
      end else if (!cfg_done) begin
         cfg_done <= 1'b1;
         cfg      <= ccsw_decode(clock_mode_straps);
      end
   end

   assign wdog_en = ~OSC_WATCHDOG_DISABLE_IN;
   // once the free clock carries the cpu clock it must not be stopped
   assign free_run = wdog_en || (src != CCSW_SRC_NORMAL);

   // ------------------------------------------------------------
   // free-running pll clock
   // ------------------------------------------------------------
   assign free_fall_now = free_run && free_clk && (free_cnt == 2'(FREE_HALF_CYC - 1));
   assign free_rise     = free_run && !free_clk && (free_cnt == 2'(FREE_HALF_CYC - 1));

   // pll off while the watchdog is disabled, kept running once it drives the cpu
   always_comb begin
      next_free_clk = free_clk;
      if (!free_run) begin
         next_free_clk = 1'b0;
      end else if (free_cnt == 2'(FREE_HALF_CYC - 1)) begin
         next_free_clk = ~free_clk;
      end
   end

   always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
      if (!RSTN_IN) begin
         free_cnt <= 2'h0;
         free_clk <= 1'b0;
      end else begin
         free_clk <= next_free_clk;
         if (!free_run || free_cnt == 2'(FREE_HALF_CYC - 1)) begin
            free_cnt <= 2'h0;
         end else begin
            free_cnt <= free_cnt + 2'h1;
         end
      end
   end

   // ------------------------------------------------------------
   // watchdog counter
   // ------------------------------------------------------------
   assign ovf = (src == CCSW_SRC_NORMAL) && free_rise && !xtal_edge
                && (wdog_cnt == WDOG_OVF_COUNT - 5'h01);

   always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
      if (!RSTN_IN) begin
         wdog_cnt <= 5'h00;
      end else if (!wdog_en || xtal_edge) begin
         wdog_cnt <= 5'h00;
      end else if (free_rise && wdog_cnt != WDOG_OVF_COUNT) begin
         wdog_cnt <= wdog_cnt + 5'h01;
      end
   end

   // ------------------------------------------------------------
   // source state
   // ------------------------------------------------------------
   // pending holds the current cpu level until the free clock starts a
   // fresh low phase, so no phase is cut short
   always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
      if (!RSTN_IN) begin
         src <= CCSW_SRC_NORMAL;
      end else begin
         case (src)
            CCSW_SRC_NORMAL: begin
               if (ovf) begin
                  src <= CCSW_SRC_PENDING;
               end
            end
            CCSW_SRC_PENDING: begin
               if (free_fall_now) begin
                  src <= CCSW_SRC_FREE;
               end
            end
            CCSW_SRC_FREE: begin
               src <= CCSW_SRC_FREE;
            end
            default: begin
               src <= CCSW_SRC_NORMAL;
            end
         endcase
      end
   end

   // failure interrupt request, one pulse per failure
   always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
      if (!RSTN_IN) begin
         OSC_FAIL_INTERRUPT_OUT <= 1'b0;
         CLK_FAILED_OUT         <= 1'b0;
      end else begin
         OSC_FAIL_INTERRUPT_OUT <= ovf;
         CLK_FAILED_OUT         <= CLK_FAILED_OUT | ovf;
      end
   end

   // ------------------------------------------------------------
   // multiplier: input period and phase accumulator
   // ------------------------------------------------------------
   always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
      if (!RSTN_IN) begin
         per_cnt <= '0;
         period  <= '0;
      end else if (xtal_rise) begin
         period  <= per_cnt + PERIOD_W'(1);
         per_cnt <= '0;
      end else if (per_cnt != PERIOD_MAX) begin
         per_cnt <= per_cnt + PERIOD_W'(1);
      end
   end

   assign acc_sum = acc + (PERIOD_W + 1)'(cfg.factor2);
   assign pll_tog = (period != '0) && (acc_sum >= {1'b0, period});

   // factor2 cpu phases per input period; phase realigned after
   // factor2 input transitions
   always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
      if (!RSTN_IN) begin
         acc       <= '0;
         trans_cnt <= 4'h0;
      end else if (xtal_edge && trans_cnt == cfg.factor2 - 4'h1) begin
         acc       <= '0;
         trans_cnt <= 4'h0;
      end else begin
         if (xtal_edge) begin
            trans_cnt <= trans_cnt + 4'h1;
         end
         if (pll_tog) begin
            acc <= acc_sum - {1'b0, period};
         end else if (period != '0) begin
            acc <= acc_sum;
         end
      end
   end

   // ------------------------------------------------------------
   // cpu clock selection
   // ------------------------------------------------------------
   assign use_direct = (cfg.mode == CCSW_MODE_DIRECT)
                       || (cfg.mode == CCSW_MODE_PLL && !wdog_en);

   always_comb begin
      next_cpu = CPU_CLK_OUT;
      case (src)
         CCSW_SRC_FREE: begin
            next_cpu = next_free_clk;
         end
         CCSW_SRC_PENDING: begin
            next_cpu = free_fall_now ? 1'b0 : CPU_CLK_OUT;
         end
         default: begin
            if (use_direct) begin
               next_cpu = xtal_s;
            end else if (cfg.mode == CCSW_MODE_PRESC) begin
               next_cpu = xtal_rise ? ~CPU_CLK_OUT : CPU_CLK_OUT;
            end else if (pll_tog) begin
               next_cpu = ~CPU_CLK_OUT;
            end
         end
      endcase
   end

   // clock output and its edge marker
   always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
      if (!RSTN_IN) begin
         CPU_CLK_OUT  <= 1'b0;
         CPU_EDGE_OUT <= 1'b0;
         PLL_ON_OUT   <= 1'b0;
      end else begin
         CPU_CLK_OUT  <= next_cpu;
         CPU_EDGE_OUT <= next_cpu ^ CPU_CLK_OUT;
         PLL_ON_OUT   <= free_run;
      end
   end

   assign CLOCK_MODE_OUT = cfg;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking cb @(posedge CLK_IN); endclocking
   default disable iff (!RSTN_IN);

   sequence s_pending_wait;
      src == CCSW_SRC_PENDING;
   endsequence

   sequence s_free_low;
      (src == CCSW_SRC_FREE && !CPU_CLK_OUT) [*2];
   endsequence

   chk_mode_frozen: assert property (cfg_done |=> $stable(cfg))
      else $error("clock mode changed after capture");
   chk_presc_toggle: assert property (
      src == CCSW_SRC_NORMAL && cfg.mode == CCSW_MODE_PRESC && xtal_rise
      |=> CPU_CLK_OUT != $past(CPU_CLK_OUT))
      else $error("prescaler missed an input period");
   chk_presc_hold: assert property (
      src == CCSW_SRC_NORMAL && cfg.mode == CCSW_MODE_PRESC && !xtal_rise
      |=> $stable(CPU_CLK_OUT))
      else $error("prescaler phase cut short");
   chk_direct_follow: assert property (
      src == CCSW_SRC_NORMAL && use_direct |=> CPU_CLK_OUT == $past(xtal_s))
      else $error("direct drive does not follow input");
   chk_wdog_clear: assert property (xtal_edge |=> wdog_cnt == 5'h00)
      else $error("watchdog not cleared by input edge");
   chk_wdog_ovf: assert property (
      $rose(src == CCSW_SRC_PENDING) |-> $past(wdog_cnt) == WDOG_OVF_COUNT - 5'h01
      && $past(free_rise))
      else $error("watchdog overflow at wrong count");
   chk_fail_irq: assert property (ovf |=> OSC_FAIL_INTERRUPT_OUT ##1 CLK_FAILED_OUT)
      else $error("failure interrupt missing");
   chk_switch_bound: assert property (s_pending_wait |-> ##[1:4] src == CCSW_SRC_FREE)
      else $error("switchover took too long");
   chk_free_sticky: assert property (src == CCSW_SRC_FREE |=> src == CCSW_SRC_FREE)
      else $error("left free-running source without reset");
   chk_switch_clean: assert property ($rose(src == CCSW_SRC_FREE) |-> s_free_low)
      else $error("short phase at switchover");
   chk_pll_off: assert property (!wdog_en && src == CCSW_SRC_NORMAL
      |=> !free_clk && wdog_cnt == 5'h00)
      else $error("pll running while watchdog disabled");
   chk_edge_mark: assert property ($changed(CPU_CLK_OUT) |-> CPU_EDGE_OUT)
      else $error("cpu clock edge not marked");

endmodule
`default_nettype wire

/* rtl/ccsw_pkg.sv */
// ccsw_pkg: shared constants and types for the cpu clock source block
// assumes a single 10 MHz reference clock drives all of the logic
package ccsw_pkg;

   // ------------------------------------------------------------
   // timing
   // ------------------------------------------------------------
   localparam int CLK_PERIOD_NS  = 100;  // reference clock period
   localparam int FREE_PERIOD_NS = 400;  // free-running pll period (2.5 MHz)
   localparam int FREE_HALF_CYC  = (FREE_PERIOD_NS + 2 * CLK_PERIOD_NS - 1)
                                   / (2 * CLK_PERIOD_NS);
   localparam logic [4:0] WDOG_OVF_COUNT = 5'h10;  // free cycles to overflow
   localparam int PERIOD_W        = 12;  // input period counter width
   localparam logic [PERIOD_W-1:0] PERIOD_MAX = 12'hFFF;

   // ------------------------------------------------------------
   // strap codes and factors (factor held as twice the ratio)
   // ------------------------------------------------------------
   localparam logic [2:0] STRAP_X4   = 3'h7;
   localparam logic [2:0] STRAP_X3   = 3'h6;
   localparam logic [2:0] STRAP_X2   = 3'h5;
   localparam logic [2:0] STRAP_X5   = 3'h4;
   localparam logic [2:0] STRAP_X1   = 3'h3;
   localparam logic [2:0] STRAP_X1_5 = 3'h2;
   localparam logic [2:0] STRAP_X0_5 = 3'h1;
   localparam logic [2:0] STRAP_X2_5 = 3'h0;
   localparam logic [3:0] F2_X4      = 4'h8;
   localparam logic [3:0] F2_X3      = 4'h6;
   localparam logic [3:0] F2_X2      = 4'h4;
   localparam logic [3:0] F2_X5      = 4'hA;
   localparam logic [3:0] F2_X1      = 4'h2;
   localparam logic [3:0] F2_X1_5    = 4'h3;
   localparam logic [3:0] F2_X0_5    = 4'h1;
   localparam logic [3:0] F2_X2_5    = 4'h5;

   typedef enum logic [1:0] {
      CCSW_MODE_PLL    = 2'h0,
      CCSW_MODE_DIRECT = 2'h1,
      CCSW_MODE_PRESC  = 2'h2
   } ccsw_mode_t;

   // clock source state, gray along normal -> pending -> free
   typedef enum logic [1:0] {
      CCSW_SRC_NORMAL  = 2'h0,
      CCSW_SRC_PENDING = 2'h1,
      CCSW_SRC_FREE    = 2'h3
   } ccsw_src_t;

   typedef struct packed {
      ccsw_mode_t mode;
      logic [3:0] factor2;
   } ccsw_cfg_t;

   localparam ccsw_cfg_t CFG_RESET = '{mode: CCSW_MODE_PLL, factor2: F2_X4};

   // strap code to clock generation setting
   function automatic ccsw_cfg_t ccsw_decode(input logic [2:0] code);
      ccsw_cfg_t c;
      c = '{mode: CCSW_MODE_PLL, factor2: F2_X4};
      case (code)
         STRAP_X4:   c.factor2 = F2_X4;
         STRAP_X3:   c.factor2 = F2_X3;
         STRAP_X2:   c.factor2 = F2_X2;
         STRAP_X5:   c.factor2 = F2_X5;
         STRAP_X1:   c = '{mode: CCSW_MODE_DIRECT, factor2: F2_X1};
         STRAP_X1_5: c.factor2 = F2_X1_5;
         STRAP_X0_5: c = '{mode: CCSW_MODE_PRESC, factor2: F2_X0_5};
         STRAP_X2_5: c.factor2 = F2_X2_5;
         default:    c.factor2 = F2_X4;
      endcase
      return c;
   endfunction

endpackage

/* rtl/ccsw_sync.sv */
// ccsw_sync: two-flop synchroniser for pin levels
// assumes the destination clock is the reference clock; carries no reset
// so that strap levels are already settled when reset is released
`timescale 1ns/10ps
`default_nettype none
module ccsw_sync #(
   parameter int W = 1
) (
   // clock
   input  wire logic         clk_in,
   // data
   input  wire logic [W-1:0] d_in,
   output logic      [W-1:0] q_out
);
   logic [W-1:0] meta;

   // first stage feeds only the second stage
   always_ff @(posedge clk_in) begin
      meta  <= d_in;
      q_out <= meta;
   end
endmodule
`default_nettype wire

/* dv/ccsw_xtal_model.sv */
// ccsw_xtal_model: behavioural external clock source for the crystal pin
// assumes the bench sets the high and low phase lengths in ns and starts
// or stops the source through run_in
`timescale 1ns/10ps
`default_nettype none
module ccsw_xtal_model (
   // control
   input  wire logic run_in,
   input  var  int   hi_ns_in,
   input  var  int   lo_ns_in,
   // pin
   output var  logic xtal_out
);
   // ------------------------------------------------------------
   // oscillator
   // ------------------------------------------------------------
   // toggle while running; a stopped source holds its pin still
   initial begin
      xtal_out = 1'b0;
      forever begin
         wait (run_in === 1'b1);
         #(xtal_out ? hi_ns_in : lo_ns_in);
         if (run_in === 1'b1) begin
            xtal_out = ~xtal_out;
         end
      end
   end
endmodule
`default_nettype wire

/* dv/ccsw_top_tb.sv */
// ccsw_top_tb: self-checking bench for the cpu clock source block
// assumes the crystal model in ccsw_xtal_model and a 10 MHz reference
`timescale 1ns/10ps
`default_nettype none
module ccsw_top_tb;
   import ccsw_pkg::*;
   // ------------------------------------------------------------
   // signals
   // ------------------------------------------------------------
   logic       clk, rst_n, dis, run;
   logic [2:0] straps;
   logic       xtal, cpu_clk, cpu_edge, irq, failed, pll_on;
   ccsw_cfg_t  mode;
   int         hi_ns, lo_ns, failures, checks_done, edges, irqs;
   // expected setting for each strap code
   ccsw_mode_t exp_mode [8] = '{CCSW_MODE_PLL, CCSW_MODE_PRESC, CCSW_MODE_PLL,
      CCSW_MODE_DIRECT, CCSW_MODE_PLL, CCSW_MODE_PLL, CCSW_MODE_PLL, CCSW_MODE_PLL};
   logic [3:0] exp_f2 [8] = '{F2_X2_5, F2_X0_5, F2_X1_5, F2_X1, F2_X5, F2_X2, F2_X3, F2_X4};

   ccsw_top i_dut (
      .CLK_IN                   (clk),
      .RSTN_IN                  (rst_n),
      .CRYSTAL_INPUT_IN         (xtal),
      .CLOCK_MODE_STRAP_PINS_IN (straps),
      .OSC_WATCHDOG_DISABLE_IN  (dis),
      .CPU_CLK_OUT              (cpu_clk),
      .CPU_EDGE_OUT             (cpu_edge),
      .OSC_FAIL_INTERRUPT_OUT   (irq),
      .CLK_FAILED_OUT           (failed),
      .PLL_ON_OUT               (pll_on),
      .CLOCK_MODE_OUT           (mode)
   );

   ccsw_xtal_model i_xtal (
      .run_in   (run),
      .hi_ns_in (hi_ns),
      .lo_ns_in (lo_ns),
      .xtal_out (xtal)
   );

   // ------------------------------------------------------------
   // clock, monitors, helpers
   // ------------------------------------------------------------
   // 10 MHz reference
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   // count cpu clock edges and failure pulses seen by the bench
   always @(posedge clk) begin
      edges = edges + int'(cpu_edge === 1'b1);
      irqs  = irqs + int'(irq === 1'b1);
   end

   task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp) begin
         failures++;
         $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
   endtask

   // hold reset 20 cycles with the given straps, check the idle outputs
   task automatic do_reset(input logic [2:0] code);
      @(posedge clk);
      #1 rst_n = 1'b0;
      straps = code;
      repeat (19) @(posedge clk);
      #1;
      cmp(16'({cpu_clk, cpu_edge, irq, failed, pll_on}), 16'h0);
      cmp(16'(mode), 16'(CFG_RESET));
      @(posedge clk);
      #1 rst_n = 1'b1;
      repeat (3) @(posedge clk);
      #1;
   endtask

   // cycles until the next cpu clock edge, bounded
   task automatic wait_edge(output int n);
      n = 0;
      do begin
         @(posedge clk);
         #1 n++;
      end while (cpu_edge !== 1'b1 && n < 500);
   endtask

   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   // every strap code, then strap changes after capture are ignored
   task automatic t_straps();
      for (int c = 0; c < 8; c++) begin
         do_reset(3'(c));
         straps = ~3'(c);
         repeat (4) @(posedge clk);
         #1;
         cmp(16'(mode), 16'({exp_mode[c], exp_f2[c]}));
         cmp(16'(pll_on), 16'h1);
      end
   endtask

   // input 3 cycles high, 5 low; check each cpu half against its level
   task automatic t_phases(input logic [2:0] code, input int ehi, input int elo);
      int   n;
      logic lvl;
      do_reset(code);
      wait_edge(n);
      wait_edge(n);
      repeat (4) begin
         lvl = cpu_clk;
         wait_edge(n);
         cmp(16'(n), 16'(lvl ? ehi : elo));
      end
   endtask

   // factor 4 on a 40 cycle input: 8 edges per input period
   task automatic t_pll();
      hi_ns = 2000;
      lo_ns = 2000;
      do_reset(3'h7);
      repeat (200) @(posedge clk);
      #1 edges = 0;
      repeat (160) @(posedge clk);
      #1;
      cmp(16'(edges >= 31 && edges <= 33), 16'h1);
      hi_ns = 300;
      lo_ns = 500;
   endtask

   // slow input whose halves stay under 16 free cycles never fails
   task automatic t_slow();
      hi_ns = 4000;
      lo_ns = 4000;
      do_reset(3'h3);
      irqs = 0;
      repeat (400) @(posedge clk);
      #1;
      cmp(16'({irqs[7:0], failed}), 16'h0);
      hi_ns = 300;
      lo_ns = 500;
   endtask

   // disabled watchdog ignores a dead input; enabling it then fails over
   task automatic t_fail();
      int n;
      do_reset(3'h3);
      dis = 1'b1;
      repeat (2) @(posedge clk);
      #1;
      cmp(16'(pll_on), 16'h0);
      run = 1'b0;
      repeat (8) @(posedge clk);
      #1 edges = 0;
      irqs = 0;
      repeat (150) @(posedge clk);
      #1;
      cmp(16'(edges + irqs), 16'h0);
      dis = 1'b0;
      n = 0;
      while (irq !== 1'b1 && n < 100) begin
         @(posedge clk);
         #1 n++;
      end
      cmp(16'(n >= 60 && n <= 72), 16'h1);
      @(posedge clk);
      #1;
      cmp(16'({irq, failed}), 16'h1);
      run = 1'b1;
      dis = 1'b1;
      repeat (3) wait_edge(n);
      repeat (4) begin
         wait_edge(n);
         cmp(16'(n), 16'(FREE_HALF_CYC));
      end
      cmp(16'({failed, pll_on}), 16'h3);
      dis = 1'b0;
   endtask

   // ------------------------------------------------------------
   // sequence and verdict
   // ------------------------------------------------------------
   task automatic print_verdict();
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // all scenarios end well inside 20000 cycles
   initial begin
      #2000000;
      failures++;
      print_verdict();
   end

   initial begin
      rst_n = 1'b0;
      straps = 3'h7;
      dis = 1'b0;
      run = 1'b1;
      hi_ns = 300;
      lo_ns = 500;
      failures = 0;
      checks_done = 0;
      edges = 0;
      irqs = 0;
      t_straps();
      t_phases(3'h3, 3, 5);
      t_phases(3'h1, 8, 8);
      // pll strap with the watchdog disabled falls back to the input clock
      dis = 1'b1;
      t_phases(3'h7, 3, 5);
      dis = 1'b0;
      t_pll();
      t_slow();
      t_fail();
      t_phases(3'h3, 3, 5);
      print_verdict();
   end
endmodule
`default_nettype wire
